/* src/atg_angle_tick_generator.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] Tick period register: 15-bit whole part 23..9, 9-bit fraction 8..0.
// [RULE2] Prescaler loads whole minus one; zero whole means 32768 clocks.
// [RULE3] Prescaler counts base-one clocks; at zero ticks, accumulates, reloads.
// [RULE4] Fraction adds into 9-bit accumulator; carry stalls prescaler one clock.
// [RULE5] A new period takes effect only after the next tick.
// [RULE6] High-rate: tick every eight clocks, no accumulate, stall ignored.
// [RULE7] Entering high-rate reloads eight clocks before the first tick.
// [RULE8] High-rate keeps clock/8; latest period used when normal resumes.
// [RULE9] Count reaching ticks before a tooth holds until the real tooth.
// [RULE10] Early tooth: count at clock/8 to tooth end, advance, go normal.
// [RULE11] Angle values are never skipped; every value appears in order.
// [RULE12] Angle time base counts on across teeth, optional reset at end.
// [RULE13] Estimated tooth raised when tick count reaches ticks per tooth.
// [RULE14] Modes normal, halt, high-rate change automatically on tooth timing.
// [RULE15] Software picks dummy-tooth or long-period handling of missing teeth; the code has no such select, a missing tooth just halts the count.
// [RULE16] Microcode computes whole and fraction and writes them as one word.
// [RULE17] Ticks-per-tooth is 10 bits; a tooth holds that value plus one.
// [RULE18] Ticks-per-tooth is sampled when high-rate begins and used throughout.
// [RULE19] Physical teeth during high-rate are discarded.
// [RULE20] Each angle tick is a one-cycle pulse on the system clock.
// [RULE21] Reset clears prescaler, accumulator, high-rate; no tick before a write.
module atg_angle_tick_generator (
	input  wire logic                           clock_in,
	input  wire logic                           resetn_in,
	input  wire logic                           time_base_one_in,
	input  wire logic                           period_wr_in,
	input  wire logic [atg_pkg::PERIOD_W-1:0]   period_wdata_in,
	input  wire logic [atg_pkg::TICKS_W-1:0]    ticks_per_tooth_in,
	input  wire logic                           physical_tooth_in,
	input  wire logic                           tooth_end_reset_in,
	output logic [atg_pkg::PERIOD_W-1:0]        period_rdata_out,
	output logic                                angle_tick_out,
	output logic                                estimated_tooth_out,
	output logic                                tooth_advance_out,
	output logic                                high_rate_out,
	output logic                                halt_out,
	output logic [atg_pkg::TICKS_W-1:0]         tick_count_out,
	output logic [atg_pkg::BASE_W-1:0]          angle_time_base_out
);
	import atg_pkg::*;

	// ************************************************************
	// Declarations.
	// ************************************************************

	atg_frac_if frac ();

	// Tick period register and its written flag.
	logic [PERIOD_W-1:0] period_q;
	logic [PERIOD_W-1:0] period_d;
	logic                valid_q;
	logic                valid_d;

	// Prescaler state.
	logic [PRESC_W-1:0]  presc_q;
	logic [PRESC_W-1:0]  presc_d;
	logic                loaded_q;
	logic                loaded_d;
	logic                stall_q;
	logic                stall_d;
	logic [HR_W-1:0]     hr_cnt_q;
	logic [HR_W-1:0]     hr_cnt_d;
	logic [PRESC_W-1:0]  reload;
	logic [WHOLE_W-1:0]  whole;
	logic                tick;
	logic                accumulate;
	logic                stall_use;

	// Mode and counting state.
	atg_mode_t           mode_q;
	atg_mode_t           mode_d;
	logic [TICKS_W-1:0]  cnt_q;
	logic [TICKS_W-1:0]  cnt_d;
	logic [TICKS_W-1:0]  hr_ticks_q;
	logic [TICKS_W-1:0]  hr_ticks_d;
	logic [BASE_W-1:0]   base_q;
	logic [BASE_W-1:0]   base_d;
	logic                tick_q;
	logic                est_q;
	logic                est_d;
	logic                adv_q;
	logic                adv_d;
	logic                hr_enter;
	logic                hr_leave;
	logic                high_q;
	logic                high_d;
	logic                halt_q;
	logic                halt_d;

	// ************************************************************
	// Tick period register.
	// ************************************************************

	// Stores a write whole; the read port returns what was written.
	always_comb
	begin
		period_d = period_q;
		valid_d  = valid_q;
		if (period_wr_in)
		begin
			period_d = period_wdata_in; // RULE1
			valid_d  = 1'b1;
		end
	end

	// Whole part of the stored period and its prescaler reload value.
	assign whole  = period_q[WHOLE_MSB:WHOLE_LSB]; // RULE1
	assign reload = (whole == '0) ? PRESC_ZERO_RELOAD // RULE2
		: ({1'b0, whole} - PRESC_ONE);            // RULE2

	// Fraction field goes straight to the accumulator.
	assign frac.fraction   = period_q[FRAC_MSB:0]; // RULE1
	assign frac.accumulate = accumulate;

	// ************************************************************
	// Prescaler.
	// ************************************************************

	// A pending stall is only consumed by a base-one clock in normal or halt mode.
	assign stall_use = stall_q && time_base_one_in && (mode_q != ATG_HIGH);

	// Counts down in normal and halt modes, by eight in high-rate mode.
	always_comb
	begin
		presc_d    = presc_q;
		loaded_d   = loaded_q;
		hr_cnt_d   = hr_cnt_q;
		tick       = 1'b0;
		accumulate = 1'b0;
		// A carry that arrives while a stall is used is kept.
		stall_d    = (stall_q && !stall_use) || frac.carry; // RULE4
		if (mode_q == ATG_HIGH)
		begin
			// Fixed internal reload; no fraction, stall ignored.
			if (hr_cnt_q == '0)
			begin
				tick     = 1'b1;      // RULE6
				hr_cnt_d = HR_RELOAD; // RULE6
			end
			else
			begin
				hr_cnt_d = hr_cnt_q - 3'h1;
			end
			// Latest period is loaded only as normal resumes.
			if (hr_leave)
			begin
				presc_d = reload; // RULE8
			end
		end
		else if (!loaded_q)
		begin
			// No tick is produced until a period has been written.
			if (valid_q)
			begin
				presc_d  = reload; // RULE21
				loaded_d = 1'b1;
			end
		end
		else if (time_base_one_in && !stall_q)
		begin
			if (presc_q == '0)
			begin
				tick       = 1'b1;   // RULE3
				accumulate = 1'b1;   // RULE3
				presc_d    = reload; // RULE5
			end
			else
			begin
				presc_d = presc_q - PRESC_ONE; // RULE3
			end
		end
		// Entering high-rate mode arms a full eight-clock period.
		if (hr_enter)
		begin
			hr_cnt_d = HR_RELOAD; // RULE7
		end
	end

	// ************************************************************
	// Mode control and angle counting.
	// ************************************************************

	// Mode changes follow physical teeth against estimated teeth.
	always_comb
	begin
		mode_d     = mode_q;
		cnt_d      = cnt_q;
		hr_ticks_d = hr_ticks_q;
		base_d     = base_q;
		est_d      = 1'b0;
		adv_d      = 1'b0;
		hr_enter   = 1'b0;
		hr_leave   = 1'b0;
		unique case (mode_q)
			ATG_NORMAL:
			begin
				if (tick && (cnt_q == ticks_per_tooth_in))
				begin
					est_d = 1'b1; // RULE13
					if (physical_tooth_in)
					begin
						// Tooth on time: advance and stay normal.
						adv_d = 1'b1;
						cnt_d = '0;
						base_d = tooth_end_reset_in ? '0 // RULE12
							: base_q + BASE_ONE;         // RULE12
					end
					else
					begin
						mode_d = ATG_HALT; // RULE9
					end
				end
				else if (physical_tooth_in && valid_q) // RULE21
				begin
					// Early tooth: catch up at the high rate.
					mode_d     = ATG_HIGH;           // RULE14
					hr_ticks_d = ticks_per_tooth_in; // RULE18
					hr_enter   = 1'b1;               // RULE7
				end
				else if (tick)
				begin
					cnt_d  = cnt_q + TICKS_ONE; // RULE11
					base_d = base_q + BASE_ONE; // RULE12
				end
			end
			ATG_HALT:
			begin
				// Count held; ticks are dropped until the tooth comes.
				if (physical_tooth_in)
				begin
					mode_d = ATG_NORMAL; // RULE9
					adv_d  = 1'b1;
					cnt_d  = '0;         // RULE17
					base_d = tooth_end_reset_in ? '0 // RULE12
						: base_q + BASE_ONE;         // RULE12
				end
			end
			ATG_HIGH:
			begin
				// Physical teeth are not looked at in this mode.
				if (tick) // RULE19
				begin
					if (cnt_q == hr_ticks_q)
					begin
						est_d    = 1'b1;       // RULE13
						adv_d    = 1'b1;       // RULE10
						mode_d   = ATG_NORMAL; // RULE10
						hr_leave = 1'b1;       // RULE8
						cnt_d    = '0;
						base_d   = tooth_end_reset_in ? '0 // RULE12
							: base_q + BASE_ONE;           // RULE12
					end
					else
					begin
						cnt_d  = cnt_q + TICKS_ONE; // RULE11
						base_d = base_q + BASE_ONE; // RULE11
					end
				end
			end
		endcase
		// Mode flags for the outputs follow the next mode.
		high_d = (mode_d == ATG_HIGH);
		halt_d = (mode_d == ATG_HALT);
	end

	// ************************************************************
	// State registers.
	// ************************************************************

	// Registers all state; reset clears prescaler and high-rate mode.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			period_q   <= PERIOD_RESET;
			valid_q    <= 1'b0;       // RULE21
			presc_q    <= '0;         // RULE21
			loaded_q   <= 1'b0;
			stall_q    <= 1'b0;
			hr_cnt_q   <= HR_RELOAD;
			mode_q     <= ATG_NORMAL; // RULE21
			cnt_q      <= '0;
			hr_ticks_q <= '0;
			base_q     <= '0;
			tick_q     <= 1'b0;
			est_q      <= 1'b0;
			adv_q      <= 1'b0;
			high_q     <= 1'b0;
			halt_q     <= 1'b0;
		end
		else
		begin
			period_q   <= period_d;
			valid_q    <= valid_d;
			presc_q    <= presc_d;
			loaded_q   <= loaded_d;
			stall_q    <= stall_d;
			hr_cnt_q   <= hr_cnt_d;
			mode_q     <= mode_d;
			cnt_q      <= cnt_d;
			hr_ticks_q <= hr_ticks_d;
			base_q     <= base_d;
			tick_q     <= tick;  // RULE20
			est_q      <= est_d;
			adv_q      <= adv_d;
			high_q     <= high_d;
			halt_q     <= halt_d;
		end
	end

	// ************************************************************
	// Fraction accumulator and outputs.
	// ************************************************************

	// Accumulates the fraction and reports overflow as a stall.
	atg_frac_acc u_frac_acc (
		.clock_in  (clock_in),
		.resetn_in (resetn_in),
		.frac      (frac)
	);

	// All outputs come straight from flip-flops.
	assign period_rdata_out    = period_q;
	assign angle_tick_out      = tick_q;
	assign estimated_tooth_out = est_q;
	assign tooth_advance_out   = adv_q;
	assign high_rate_out       = high_q;
	assign halt_out            = halt_q;
	assign tick_count_out      = cnt_q;
	assign angle_time_base_out = base_q;

endmodule // atg_angle_tick_generator
`default_nettype wire

/* src/atg_pkg.sv */
// ****************************************************************
// Constants of the angle tick generator.
// ****************************************************************
package atg_pkg;

	// Tick period register layout.
	localparam int PERIOD_W  = 24;
	localparam int WHOLE_W   = 15;
	localparam int WHOLE_LSB = 9;
	localparam int WHOLE_MSB = 23;
	localparam int FRAC_W    = 9;
	localparam int FRAC_MSB  = 8;
	localparam logic [PERIOD_W-1:0] PERIOD_RESET = 24'h000000;

	// Prescaler width and the reload used for a whole part of zero.
	localparam int PRESC_W = 16;
	localparam logic [PRESC_W-1:0] PRESC_ZERO_RELOAD = 16'h7fff;
	localparam logic [PRESC_W-1:0] PRESC_ONE         = 16'h0001;

	// High-rate prescaler: a tick every eight system clocks.
	localparam int HR_W = 3;
	localparam logic [HR_W-1:0] HR_RELOAD = 3'h7;

	// Ticks-per-tooth field and angle time base widths.
	localparam int TICKS_W = 10;
	localparam int BASE_W  = 24;
	localparam logic [TICKS_W-1:0] TICKS_ONE = 10'h001;
	localparam logic [BASE_W-1:0]  BASE_ONE  = 24'h000001;

	// Angle counter modes, Gray coded away from normal.
	typedef enum logic [1:0] {
		ATG_NORMAL = 2'b00,
		ATG_HIGH   = 2'b01,
		ATG_HALT   = 2'b10
	} atg_mode_t;

endpackage

/* src/atg_frac_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Link between the prescaler and the fraction accumulator.
// ****************************************************************
interface atg_frac_if;
	import atg_pkg::*;

	logic                accumulate;
	logic [FRAC_W-1:0]   fraction;
	logic                carry;

	// The prescaler side issues accumulate pulses and takes the carry.
	modport prescaler (
		output accumulate,
		output fraction,
		input  carry
	);

	// The accumulator side adds the fraction and reports overflow.
	modport accum (
		input  accumulate,
		input  fraction,
		output carry
	);

endinterface
`default_nettype wire

/* src/atg_frac_acc.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Nine-bit fraction accumulator.
// ****************************************************************
module atg_frac_acc (
	input  wire logic   clock_in,
	input  wire logic   resetn_in,
	atg_frac_if.accum   frac
);
	import atg_pkg::*;

	logic [FRAC_W-1:0] acc_q;
	logic [FRAC_W-1:0] acc_d;
	logic              carry_q;
	logic              carry_d;
	logic [FRAC_W:0]   sum;

	// Adds the fraction on each accumulate pulse; carry is one cycle.
	always_comb
	begin
		sum     = {1'b0, acc_q} + {1'b0, frac.fraction};
		acc_d   = acc_q;
		carry_d = 1'b0;
		if (frac.accumulate)
		begin
			acc_d   = sum[FRAC_W-1:0]; // RULE4
			carry_d = sum[FRAC_W];     // RULE4
		end
	end

	// Registers the accumulator, cleared by reset.
	always_ff @(posedge clock_in)
	begin
		if (!resetn_in)
		begin
			acc_q   <= '0; // RULE21
			carry_q <= 1'b0;
		end
		else
		begin
			acc_q   <= acc_d;
			carry_q <= carry_d;
		end
	end

	assign frac.carry = carry_q;

endmodule // atg_frac_acc
`default_nettype wire

/* tb/atg_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Microengine side: period writes and the time base one clock.
// ****
module atg_engine_model (
	input  wire logic                         clock_in,
	input  wire logic                         req_in,
	input  wire logic [atg_pkg::WHOLE_W-1:0]  whole_in,
	input  wire logic [atg_pkg::FRAC_W-1:0]   frac_in,
	input  wire logic [1:0]                   div_in,
	output logic                              period_wr_out,
	output logic [atg_pkg::PERIOD_W-1:0]      period_wdata_out,
	output logic                              base_one_out
);
	import atg_pkg::*;

	int cnt;

	// Quiet outputs from time zero.
	initial
	begin
		cnt = 0;
		period_wr_out = 1'b0;
		period_wdata_out = '0;
		base_one_out = 1'b0;
	end

	// One whole word per request; an idle bus shows the inverse.
	always @(posedge clock_in)
	begin
		period_wr_out <= #1 req_in;
		period_wdata_out <= #1 req_in ? {whole_in, frac_in} : ~period_wdata_out;
		base_one_out <= #1 (cnt == 0);
		cnt = (cnt + 1 >= div_in) ? 0 : cnt + 1;
	end
endmodule // atg_engine_model
`default_nettype wire

/* tb/atg_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks of the angle tick generator.
// ****
module atg_assertions (
	input wire logic                          clock_in,
	input wire logic                          resetn_in,
	input wire logic                          period_wr_in,
	input wire logic [atg_pkg::PERIOD_W-1:0]  period_wdata_in,
	input wire logic [atg_pkg::TICKS_W-1:0]   ticks_per_tooth_in,
	input wire logic                          physical_tooth_in,
	input wire logic                          tooth_end_reset_in,
	input wire logic [atg_pkg::PERIOD_W-1:0]  period_rdata_out,
	input wire logic                          angle_tick_out,
	input wire logic                          estimated_tooth_out,
	input wire logic                          tooth_advance_out,
	input wire logic                          high_rate_out,
	input wire logic                          halt_out,
	input wire logic [atg_pkg::TICKS_W-1:0]   tick_count_out,
	input wire logic [atg_pkg::BASE_W-1:0]    angle_time_base_out
);
	import atg_pkg::*;

	logic written_q;
	logic written_d;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	// Remembers whether a period was written since reset.
	always_comb written_d = written_q | period_wr_in;
	always_ff @(posedge clock_in) written_q <= resetn_in ? written_d : 1'b0;

	a_tick_needs_write: assert property (angle_tick_out |-> written_q)
		else $error("tick before any period write");
	a_rdata_write: assert property (period_wr_in
		|=> period_rdata_out == $past(period_wdata_in))
		else $error("period not stored");
	a_rdata_keep: assert property (!period_wr_in
		|=> $stable(period_rdata_out))
		else $error("period changed without write");
	a_hr_entry: assert property (!high_rate_out && !halt_out
		&& physical_tooth_in && written_q
		&& ({1'b0, tick_count_out} + 11'h002
		< {1'b0, ticks_per_tooth_in}) |=> high_rate_out)
		else $error("early tooth did not start high rate");
	a_hr_entry_gap: assert property ($rose(high_rate_out)
		|=> !angle_tick_out [*7])
		else $error("high rate tick too soon after entry");
	a_hr_spacing: assert property (high_rate_out && angle_tick_out
		|=> (!angle_tick_out || !high_rate_out) [*7])
		else $error("high rate ticks closer than eight clocks");
	a_halt_enter: assert property (estimated_tooth_out
		&& !tooth_advance_out && !high_rate_out
		&& !$past(physical_tooth_in) && !$past(physical_tooth_in, 2)
		|-> halt_out)
		else $error("estimate without tooth did not halt");
	a_halt_hold: assert property (halt_out && !physical_tooth_in
		|=> $stable(tick_count_out) && $stable(angle_time_base_out))
		else $error("count moved while halted");
	a_halt_release: assert property (halt_out && physical_tooth_in
		|=> tooth_advance_out && !halt_out && tick_count_out == '0)
		else $error("tooth did not release halt");
	a_base_step: assert property ($changed(angle_time_base_out)
		&& !$past(tooth_end_reset_in)
		|-> angle_time_base_out == $past(angle_time_base_out) + BASE_ONE)
		else $error("angle value skipped");
	a_base_advance: assert property (tooth_advance_out
		&& !$past(tooth_end_reset_in)
		|-> angle_time_base_out == $past(angle_time_base_out) + BASE_ONE)
		else $error("base did not step on advance");
	a_base_clear: assert property (tooth_advance_out
		&& $past(tooth_end_reset_in) |-> angle_time_base_out == '0)
		else $error("base not cleared at tooth end");
endmodule // atg_assertions

bind atg_angle_tick_generator atg_assertions i_chk (.clock_in, .resetn_in,
	.period_wr_in, .period_wdata_in, .ticks_per_tooth_in, .physical_tooth_in,
	.tooth_end_reset_in, .period_rdata_out, .angle_tick_out,
	.estimated_tooth_out, .tooth_advance_out, .high_rate_out, .halt_out,
	.tick_count_out, .angle_time_base_out);
`default_nettype wire

/* tb/atg_angle_tick_generator_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Self-checking bench of the angle tick generator.
// ****
module atg_angle_tick_generator_tb;
	import atg_pkg::*;

	logic                 clock_in, resetn_in, req, tooth, ter, wr, base_one;
	logic                 tick, est, adv, hr, halt;
	logic [WHOLE_W-1:0]   whole;
	logic [FRAC_W-1:0]    frac;
	logic [1:0]           div;
	logic [TICKS_W-1:0]   ticks, count, held;
	logic [PERIOD_W-1:0]  wdata, rdata, base;
	int                   miscompares, num_checks, seed, n, s, w, d, wold;

	atg_engine_model i_eng (.clock_in(clock_in), .req_in(req), .whole_in(whole),
		.frac_in(frac), .div_in(div), .period_wr_out(wr),
		.period_wdata_out(wdata), .base_one_out(base_one));

	atg_angle_tick_generator i_dut (.clock_in(clock_in), .resetn_in(resetn_in),
		.time_base_one_in(base_one), .period_wr_in(wr), .period_wdata_in(wdata),
		.ticks_per_tooth_in(ticks), .physical_tooth_in(tooth),
		.tooth_end_reset_in(ter), .period_rdata_out(rdata),
		.angle_tick_out(tick), .estimated_tooth_out(est),
		.tooth_advance_out(adv), .high_rate_out(hr), .halt_out(halt),
		.tick_count_out(count), .angle_time_base_out(base));

	// Prints the verdict and ends the run.
	task automatic end_sim;
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Compares a design value with its expectation.
	task automatic chk(input logic [PERIOD_W-1:0] got, input logic [PERIOD_W-1:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares a measured tick spacing with its expectation.
	task automatic chk_gap(input int got, input int exp);
		num_checks++;
		if (got != exp)
		begin
			miscompares++;
			$display("wrong value at %0t: gap %0d expected %0d", $time, got, exp);
		end
	endtask

	// Clocks between ticks for a whole part and a base-one divider.
	function automatic int tick_clocks(input int wh, input int dv);
		return ((wh == 0) ? 32768 : wh) * dv;
	endfunction

	// Moves k clock edges on, landing just after the last one.
	task automatic step(input int k);
		repeat (k) @(posedge clock_in);
		#1;
	endtask

	// Writes one period word through the engine and reads it back.
	task automatic put(input int wh, input int fr);
		req = 1'b1;
		whole = wh[14:0];
		frac = fr[8:0];
		step(1);
		req = 1'b0;
		step(2);
		chk(rdata, {wh[14:0], fr[8:0]});
	endtask

	// Counts clocks up to the next tick.
	task automatic gap(output int k);
		k = 0;
		do
		begin
			step(1);
			k++;
		end
		while (tick !== 1'b1 && k < 40000);
	endtask

	// Waits for an estimate or an advance, keeping the last count seen.
	task automatic wait_hi(input bit sel);
		n = 0;
		while ((sel ? adv : est) !== 1'b1 && n < 20000)
		begin
			held = count;
			step(1);
			n++;
		end
	endtask

	// One physical tooth pulse.
	task automatic pulse;
		tooth = 1'b1;
		step(1);
		tooth = 1'b0;
	endtask

	// System clock of 20 ns.
	initial
	begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// Cuts a hang short.
	initial
	begin
		repeat (60000) @(posedge clock_in);
		miscompares++;
		end_sim;
	end

	// Main sequence.
	initial
	begin
		seed = 32'h9303;
		miscompares = 0;
		num_checks = 0;
		resetn_in = 1'b0;
		{req, tooth, ter, whole, frac} = '0;
		div = 2'h1;
		ticks = 10'h002;
		repeat (6) @(posedge clock_in);
		#1;
		resetn_in = 1'b1;
		step(20);
		chk(tick, 1'b0);
		// Halt: estimate before the tooth, then the tooth releases it.
		put(5, 0);
		wait_hi(0);
		chk(est, 1'b1);
		chk(halt, 1'b1);
		step(5);
		chk(count, 10'h002);
		// The tooth end clears the angle time base this once.
		ter = 1'b1;
		pulse();
		ter = 1'b0;
		chk(adv, 1'b1);
		chk(count, 10'h000);
		chk(base, 24'h000000);
		// Long expected tooth: no estimate falls in the period checks that follow.
		ticks = 10'h3ff;
		wold = 5;
		// Random periods and base rates; a write lands mid-period.
		for (int i = 0; i < 3; i++)
		begin
			w = 5 + $unsigned($random(seed)) % 8;
			d = 1 + $unsigned($random(seed)) % 2;
			div = d[1:0];
			gap(n);
			gap(n);
			chk_gap(n, tick_clocks(wold, d));
			put(w, 0);
			gap(n);
			chk_gap(n + 3, tick_clocks(wold, d));
			gap(n);
			chk_gap(n, tick_clocks(w, d));
			wold = w;
		end
		// Half a clock of fraction: four ticks take eighteen clocks.
		div = 2'h1;
		put(4, 9'h100);
		repeat (3) gap(n);
		s = 0;
		repeat (4)
		begin
			gap(n);
			s += n;
		end
		chk_gap(s, 18);
		put(0, 0);
		gap(n);
		gap(n);
		chk_gap(n, tick_clocks(0, 1));
		// Early tooth: high rate to the end of the tooth.
		pulse();
		chk(hr, 1'b1);
		put(6, 0);
		ticks = 10'h3fe;
		gap(n);
		gap(n);
		chk_gap(n, 8);
		pulse();
		chk(hr, 1'b1);
		wait_hi(1);
		chk(held, 10'h3ff);
		chk(count, 10'h000);
		step(1);
		chk(hr, 1'b0);
		gap(n);
		gap(n);
		chk_gap(n, tick_clocks(6, 1));
		end_sim;
	end
endmodule // atg_angle_tick_generator_tb
`default_nettype wire
